//--- rtl/fwh_header_tail.sv
`timescale 1ns/1ns
// Contract
// - EEPROM present fills hint during post-reset load
// - No EEPROM: hint reads 0402h
// - Only latency bits 11-8 EEPROM-loadable
// - Only grant bits 3-0 EEPROM-loadable
// - Hint restored only by global reset
// - Swap bit set byte-reverses every quadlet
// - Control bits 31-1 read zero, writes ignored
// - Next-capability pointer reads 00h
// - Capability code reads 01h
module fwh_header_tail
	import fwh_pkg::*;
(
	input wire logic clock, // 20 MHz configuration clock
	input wire logic reset_n, // Global reset, active low
	input wire logic function_reset, // Function or bus reset, synchronous
	input wire logic eeprom_present, // Serial EEPROM detected
	input wire fwh_eeprom_load_t eeprom_load, // Loader strobe and nibbles
	input wire fwh_cfg_request_t cfg_request, // Configuration access
	output fwh_cfg_answer_t cfg_answer, // Registered read answer
	output logic byte_swap_enable, // Big-endian mode
	input wire fwh_quadlet_t pci_write_quadlet, // Quadlet from the bus
	output fwh_quadlet_t core_write_quadlet, // Quadlet toward the core
	input wire fwh_quadlet_t core_read_quadlet, // Quadlet from the core
	output fwh_quadlet_t pci_read_quadlet // Quadlet toward the bus
);

	// ------------------------------------------------------------
	// Quadlet orientation
	// ------------------------------------------------------------
	// Big-endian hosts see each quadlet with its bytes reversed
	function automatic logic [31:0] fwh_orient(input logic swap, input logic [31:0] quadlet);
		logic [7:0] lane0;
		logic [7:0] lane1;
		logic [7:0] lane2;
		logic [7:0] lane3;
		lane0 = quadlet[7:0];
		lane1 = quadlet[15:8];
		lane2 = quadlet[23:16];
		lane3 = quadlet[31:24];
		if (swap) begin
			fwh_orient = {lane0, lane1, lane2, lane3};
		end else begin
			fwh_orient = {lane3, lane2, lane1, lane0};
		end
	endfunction

	// Idle cycles carry zero data so a stale quadlet never lingers on the port
	function automatic fwh_quadlet_t fwh_pass_quadlet(input logic swap, input fwh_quadlet_t quadlet);
		fwh_quadlet_t passed;
		passed = '0;
		if (quadlet.valid) begin
			passed.valid = 1'b1;
			passed.data = fwh_orient(swap, quadlet.data);
		end
		fwh_pass_quadlet = passed;
	endfunction

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	function automatic logic fwh_hits(input logic [5:0] dword_address, input logic [7:0] offset);
		fwh_hits = (dword_address == offset[7:2]);
	endfunction

	// Only the control dword takes host writes, and only its lowest lane matters
	function automatic logic fwh_control_write(input fwh_cfg_request_t request);
		logic lane_zero;
		logic hit;
		lane_zero = request.byte_enable[0];
		hit = fwh_hits(request.dword_address, HOST_CONTROLLER_CONTROL_OFFSET);
		fwh_control_write = request.write && lane_zero && hit;
	endfunction

	// ------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------
	// Function reset wins over a host write in the same cycle
	function automatic logic fwh_next_swap(input logic clear, input fwh_cfg_request_t request, input logic current);
		logic swap;
		swap = current;
		if (clear) begin
			swap = HOST_CONTROLLER_CONTROL_RESET;
		end else if (fwh_control_write(request)) begin
			swap = request.write_data[BYTE_SWAP_BIT];
		end
		fwh_next_swap = swap;
	endfunction

	// ------------------------------------------------------------
	// Arbitration hint
	// ------------------------------------------------------------
	// A strobe without a detected EEPROM is not a load
	function automatic logic fwh_load_taken(input logic present, input fwh_eeprom_load_t load);
		fwh_load_taken = present && load.valid;
	endfunction

	// Upper nibble of each field is not loadable and keeps its default
	function automatic logic [7:0] fwh_loaded_field(input logic [7:0] default_value, input logic [3:0] low_nibble);
		fwh_loaded_field = {default_value[7:4], low_nibble};
	endfunction

	// Hint fills the upper half of its dword; the lower half lies outside this block
	function automatic logic [31:0] fwh_hint_word(input logic [7:0] latency, input logic [7:0] grant);
		logic [31:0] fields;
		fields = {16'h0000, latency, grant};
		fwh_hint_word = fields << HINT_LANE_SHIFT;
	endfunction

	// ------------------------------------------------------------
	// Read words
	// ------------------------------------------------------------
	function automatic logic [31:0] fwh_control_word(input logic swap);
		logic [31:0] word;
		word = 32'h0000_0000;
		word[BYTE_SWAP_BIT] = swap;
		fwh_control_word = word;
	endfunction

	function automatic logic [31:0] fwh_header_word();
		fwh_header_word = {16'h0000, NEXT_CAPABILITY_POINTER, CAPABILITY_CODE};
	endfunction

	// Configuration reads are never byte-swapped; the swap bit governs the quadlet path
	function automatic logic [31:0] fwh_read_word(input logic [5:0] dword_address, input logic [7:0] latency,
			input logic [7:0] grant, input logic swap);
		logic [31:0] word;
		word = UNMAPPED_READ_VALUE;
		if (fwh_hits(dword_address, ARBITRATION_HINT_OFFSET)) begin
			word = fwh_hint_word(latency, grant);
		end else if (fwh_hits(dword_address, HOST_CONTROLLER_CONTROL_OFFSET)) begin
			word = fwh_control_word(swap);
		end else if (fwh_hits(dword_address, POWER_CAPABILITY_HEADER_OFFSET)) begin
			word = fwh_header_word();
		end
		fwh_read_word = word;
	endfunction

	// Every access is answered one cycle later; only reads carry data
	function automatic fwh_cfg_answer_t fwh_answer(input fwh_cfg_request_t request, input fwh_state_t current);
		fwh_cfg_answer_t answer;
		answer.ack = request.read || request.write;
		answer.read_data = UNMAPPED_READ_VALUE;
		if (request.read) begin
			answer.read_data = fwh_read_word(request.dword_address, current.latency_request,
				current.grant_request, current.byte_swap);
		end
		fwh_answer = answer;
	endfunction

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	fwh_state_t state;
	fwh_state_t next_state;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		next_state = state;

		// Loader is taken once per global reset
		case (state.load_state)
			FWH_AWAIT_LOAD: begin
				if (fwh_load_taken(eeprom_present, eeprom_load)) begin
					next_state.latency_request =
						fwh_loaded_field(LATENCY_REQUEST_RESET, eeprom_load.latency_low);
					next_state.grant_request =
						fwh_loaded_field(GRANT_REQUEST_RESET, eeprom_load.grant_low);
					next_state.load_state = FWH_LOAD_DONE;
				end else begin
					next_state.load_state = FWH_AWAIT_LOAD;
				end
			end
			FWH_LOAD_DONE: begin
				// Later strobes are dropped; only global reset reopens the loader
				next_state.load_state = FWH_LOAD_DONE;
			end
			default: begin
				next_state.load_state = FWH_AWAIT_LOAD;
			end
		endcase

		// Function and bus resets clear the control bit only, never the hint
		next_state.byte_swap = fwh_next_swap(function_reset, cfg_request, state.byte_swap);
		next_state.cfg_answer = fwh_answer(cfg_request, state);
		next_state.to_core = fwh_pass_quadlet(state.byte_swap, pci_write_quadlet);
		next_state.to_pci = fwh_pass_quadlet(state.byte_swap, core_read_quadlet);
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state.load_state <= FWH_AWAIT_LOAD;
			state.latency_request <= LATENCY_REQUEST_RESET;
			state.grant_request <= GRANT_REQUEST_RESET;
			state.byte_swap <= HOST_CONTROLLER_CONTROL_RESET;
			state.cfg_answer.ack <= 1'b0;
			state.cfg_answer.read_data <= UNMAPPED_READ_VALUE;
			state.to_core.valid <= 1'b0;
			state.to_core.data <= 32'h0000_0000;
			state.to_pci.valid <= 1'b0;
			state.to_pci.data <= 32'h0000_0000;
		end else begin
			state <= next_state;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign cfg_answer = state.cfg_answer;
	assign byte_swap_enable = state.byte_swap;
	assign core_write_quadlet = state.to_core;
	assign pci_read_quadlet = state.to_pci;

endmodule

//--- rtl/fwh_pkg.sv
package fwh_pkg;

	// ------------------------------------------------------------
	// Configuration offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] ARBITRATION_HINT_OFFSET = 8'h3e;
	localparam logic [7:0] HOST_CONTROLLER_CONTROL_OFFSET = 8'h40;
	localparam logic [7:0] POWER_CAPABILITY_HEADER_OFFSET = 8'h44;

	// ------------------------------------------------------------
	// Field positions and values after reset
	// ------------------------------------------------------------
	localparam int LATENCY_REQUEST_LSB = 8;
	localparam int GRANT_REQUEST_LSB = 0;
	localparam int HINT_LANE_SHIFT = 16;
	localparam int BYTE_SWAP_BIT = 0;
	localparam logic [7:0] LATENCY_REQUEST_RESET = 8'h04;
	localparam logic [7:0] GRANT_REQUEST_RESET = 8'h02;
	localparam logic [15:0] ARBITRATION_HINT_RESET = 16'h0402;
	localparam logic HOST_CONTROLLER_CONTROL_RESET = 1'h0;
	localparam logic [7:0] NEXT_CAPABILITY_POINTER = 8'h00;
	localparam logic [7:0] CAPABILITY_CODE = 8'h01;
	localparam logic [31:0] UNMAPPED_READ_VALUE = 32'h0000_0000;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic {
		FWH_AWAIT_LOAD,
		FWH_LOAD_DONE
	} fwh_load_state_t;

	typedef struct packed {
		logic read;
		logic write;
		logic [5:0] dword_address;
		logic [3:0] byte_enable;
		logic [31:0] write_data;
	} fwh_cfg_request_t;

	typedef struct packed {
		logic ack;
		logic [31:0] read_data;
	} fwh_cfg_answer_t;

	typedef struct packed {
		logic valid;
		logic [31:0] data;
	} fwh_quadlet_t;

	typedef struct packed {
		logic valid;
		logic [3:0] latency_low;
		logic [3:0] grant_low;
	} fwh_eeprom_load_t;

	typedef struct packed {
		fwh_load_state_t load_state;
		logic [7:0] latency_request;
		logic [7:0] grant_request;
		logic byte_swap;
		fwh_cfg_answer_t cfg_answer;
		fwh_quadlet_t to_core;
		fwh_quadlet_t to_pci;
	} fwh_state_t;

endpackage

//--- verif/fwh_header_tail_sva.sv
`timescale 1ns/1ns
module fwh_header_tail_sva
	import fwh_pkg::*;
(
	input wire logic clock, // Clock
	input wire logic reset_n, // Reset
	input wire logic function_reset, // Reset
	input wire fwh_cfg_request_t cfg_request, // Access
	input wire fwh_cfg_answer_t cfg_answer, // Answer
	input wire logic byte_swap_enable, // Swap
	input wire fwh_quadlet_t pci_write_quadlet, // In
	input wire fwh_quadlet_t core_write_quadlet, // Out
	input wire fwh_quadlet_t core_read_quadlet, // In
	input wire fwh_quadlet_t pci_read_quadlet // Out
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	wire rq = cfg_request.read;
	wire [5:0] ad = cfg_request.dword_address;
	wire wc = cfg_request.write && ad == 6'h10 && cfg_request.byte_enable[0];
	function automatic logic [31:0] sw(input logic s, input logic [31:0] d);
		return s ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
	endfunction
	a_ack_follows: assert property ((rq || cfg_request.write) |=> cfg_answer.ack) else $error("no ack");
	a_ctrl_reserved: assert property (rq && !cfg_request.write && ad == 6'h10 |=>
		cfg_answer.read_data == {31'h0, $past(byte_swap_enable)}) else $error("control read");
	a_header_const: assert property (rq && ad == 6'h11 |=> cfg_answer.read_data == 32'h1) else $error("header");
	a_hint_fields: assert property (rq && ad == 6'h0f |=> cfg_answer.read_data[15:0] == 16'h0
		&& cfg_answer.read_data[31:28] == 4'h0 && cfg_answer.read_data[23:20] == 4'h0) else $error("hint");
	a_swap_write: assert property (wc && !function_reset |=>
		byte_swap_enable == $past(cfg_request.write_data[0])) else $error("swap write");
	a_swap_clear: assert property (function_reset |=> !byte_swap_enable) else $error("swap clear");
	a_core_swap: assert property (pci_write_quadlet.valid |=> core_write_quadlet.valid &&
		core_write_quadlet.data == sw($past(byte_swap_enable), $past(pci_write_quadlet.data))) else $error("core");
	a_pci_swap: assert property (core_read_quadlet.valid |=> pci_read_quadlet.valid &&
		pci_read_quadlet.data == sw($past(byte_swap_enable), $past(core_read_quadlet.data))) else $error("pci");
	c_swap_on: cover property (wc && cfg_request.write_data[0]);
	c_hint_read: cover property (rq && ad == 6'h0f);
	c_quad_swapped: cover property (byte_swap_enable && pci_write_quadlet.valid);
endmodule
bind fwh_header_tail fwh_header_tail_sva chk (.clock(clock), .reset_n(reset_n), .function_reset(function_reset),
	.cfg_request(cfg_request), .cfg_answer(cfg_answer), .byte_swap_enable(byte_swap_enable),
	.pci_write_quadlet(pci_write_quadlet), .core_write_quadlet(core_write_quadlet),
	.core_read_quadlet(core_read_quadlet), .pci_read_quadlet(pci_read_quadlet));

//--- verif/fwh_header_tail_tb.sv
`timescale 1ns/1ns
module fwh_header_tail_tb import fwh_pkg::*;;
	logic clock = 0, reset_n = 0, function_reset = 0, eeprom_present = 0, byte_swap_enable;
	fwh_eeprom_load_t eeprom_load = '0;
	fwh_quadlet_t pci_write_quadlet = '0, core_read_quadlet = '0, core_write_quadlet, pci_read_quadlet;
	fwh_cfg_request_t cfg_request;
	fwh_cfg_answer_t cfg_answer;
	logic [31:0] expected[$], r;
	int fail_count = 0, checks_done = 0;
	always #25 clock = ~clock;
	fwh_host_model host (.clock(clock), .req(cfg_request));
	fwh_header_tail uut (.clock(clock), .reset_n(reset_n), .function_reset(function_reset),
		.eeprom_present(eeprom_present), .eeprom_load(eeprom_load), .cfg_request(cfg_request),
		.cfg_answer(cfg_answer), .byte_swap_enable(byte_swap_enable), .pci_write_quadlet(pci_write_quadlet),
		.core_write_quadlet(core_write_quadlet), .core_read_quadlet(core_read_quadlet),
		.pci_read_quadlet(pci_read_quadlet));
	task automatic cmp(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	always @(negedge clock) begin
		if (cfg_answer.ack) cmp(cfg_answer.read_data, expected.pop_front(), "read_data");
		if (core_write_quadlet.valid) cmp(core_write_quadlet.data, expected.pop_front(), "core");
		if (pci_read_quadlet.valid) cmp(pci_read_quadlet.data, expected.pop_front(), "pci");
	end
	task automatic rd(input logic [5:0] a, input logic [31:0] e);
		expected.push_back(e);
		host.access(1'b0, a, 32'h0);
	endtask
	// Write acks are answered too, with no data on the bus
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		expected.push_back(32'h0);
		host.access(1'b1, a, d);
	endtask
	task automatic quad(input logic s);
		r = $urandom;
		repeat (2) expected.push_back(s ? {r[7:0], r[15:8], r[23:16], r[31:24]} : r);
		pci_write_quadlet <= '{1'b1, r};
		core_read_quadlet <= '{1'b1, r};
		@(posedge clock);
		pci_write_quadlet <= '0;
		core_read_quadlet <= '0;
		@(posedge clock);
	endtask
	task automatic print_verdict();
		$display("checks %0d failures %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#200000;
		fail_count++;
		print_verdict();
	end
	initial begin
		void'($urandom(87773));
		repeat (16) @(posedge clock);
		reset_n <= 1;
		@(posedge clock);
		rd(6'h0f, 32'h0402_0000);
		eeprom_load <= '{1'b1, 4'h9, 4'h9};
		@(posedge clock);
		eeprom_present <= 1;
		eeprom_load <= '{1'b1, 4'h5, 4'hc};
		@(posedge clock);
		eeprom_load <= '{1'b1, 4'h3, 4'h3};
		function_reset <= 1;
		@(posedge clock);
		eeprom_load <= '0;
		function_reset <= 0;
		wr(6'h0f, $urandom);
		rd(6'h0f, 32'h050c_0000);
		wr(6'h10, $urandom | 32'h1);
		rd(6'h10, 32'h1);
		quad(1'b1);
		function_reset <= 1;
		@(posedge clock);
		function_reset <= 0;
		rd(6'h10, 32'h0);
		quad(1'b0);
		wr(6'h11, $urandom);
		rd(6'h11, 32'h1);
		rd(6'h20, 32'h0);
		reset_n <= 0;
		@(posedge clock);
		reset_n <= 1;
		@(posedge clock);
		rd(6'h0f, 32'h0402_0000);
		cmp(expected.size(), 32'h0, "pending answers");
		print_verdict();
	end
endmodule

//--- verif/fwh_host_model.sv
`timescale 1ns/1ns
module fwh_host_model
	import fwh_pkg::*;
(
	input wire logic clock, // Bus clock
	output fwh_cfg_request_t req // Access
);
	initial req = '0;
	// Idle edge after each access keeps back-to-back calls legal
	task automatic access(input logic wr, input logic [5:0] a, input logic [31:0] d);
		req <= '{!wr, wr, a, 4'hf, d};
		@(posedge clock);
		req <= '0;
		@(posedge clock);
	endtask
endmodule
